//--- logic/opgen_params.svh
// Constants for the operand address generator: prebyte codes,
// page and step values, lengths and fixed levels.
// Assumes it is included once by each file that needs the values.
`ifndef OPGEN_PARAMS_SVH
`define OPGEN_PARAMS_SVH

`define PREBYTE_INDEX_SWAP      8'h90
`define PREBYTE_INDIRECT_SWAP   8'h91
`define PREBYTE_INDIRECT        8'h92

`define PAGE_ZERO_HIGH          8'h00
`define ADDR_STEP               16'h0001

`define OPCODE_LEN              3'h1
`define PREBYTE_LEN             3'h1
`define NO_LEN                  3'h0

`define EXTRA_NONE              2'h0
`define EXTRA_ONE               2'h1
`define EXTRA_TWO               2'h2

`define MASK_LEVEL_SET          2'h3
`define MASK_LEVEL_RESET        2'h0

`define FIRST_BYTE              1'b0
`define SECOND_BYTE             1'b1

`endif

//--- logic/opgen_pkg.sv
// Types shared by the operand address generator and its bench.
// Assumes opgen_params.svh is on the include path.
package opgen_pkg;

    // Seventeen operand addressing modes
    typedef enum logic [4:0] {
        mode_inh, mode_imm, mode_dir_s, mode_dir_l,
        mode_idx_0, mode_idx_s, mode_idx_l,
        mode_ind_s, mode_ind_l, mode_indidx_s, mode_indidx_l,
        mode_rel_d, mode_rel_i,
        mode_bit_d, mode_bit_i, mode_bitrel_d, mode_bitrel_i
    } addr_mode_t;

    typedef enum logic [1:0] {
        mask_none, mask_set, mask_reset
    } mask_op_t;

    typedef enum logic [1:0] {
        st_idle, st_opnd, st_ptr, st_finish
    } dec_state_t;

    typedef struct packed {
        logic [7:0]  prebyte;
        addr_mode_t  mode;
        logic        rmw;
        mask_op_t    mask_op;
        logic [15:0] pc;
    } dec_req_t;

    typedef struct packed {
        logic        valid;
        logic        error;
        addr_mode_t  mode;
        logic        use_y;
        logic [2:0]  length;
        logic        ea_valid;
        logic [15:0] ea;
        logic        imm_valid;
        logic [7:0]  imm;
        logic        branch_valid;
        logic [15:0] branch_target;
        logic        mask_write;
        logic [1:0]  mask_level;
    } dec_res_t;

endpackage : opgen_pkg

//--- logic/cpu_operand_address_generator.sv
// Operand address generator: takes a decoded instruction, applies the
// prebyte, fetches operand bytes and page-zero pointers, and returns the
// effective address, immediate value, branch target and length.
// Assumes a byte-wide memory bus that answers each read with mem_ack,
// and a fetch unit that presents the addressing mode of each opcode.
module cpu_operand_address_generator
    import opgen_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire opgen_pkg::dec_req_t req,
    input  wire logic [7:0]         index_x,
    input  wire logic [7:0]         index_y,
    output logic                    mem_req,
    output logic [15:0]             mem_addr,
    input  wire logic [7:0]         mem_rdata,
    input  wire logic               mem_ack,
    output opgen_pkg::dec_res_t     res
);
    import opgen_pkg::*;
    `include "opgen_params.svh"

    // Operand bytes that follow the opcode for each mode
    function automatic logic [1:0] extra_bytes(input addr_mode_t m);
        case (m)
            mode_inh, mode_idx_0:                 extra_bytes = `EXTRA_NONE;
            mode_dir_l, mode_idx_l:               extra_bytes = `EXTRA_TWO;
            mode_bitrel_d, mode_bitrel_i:         extra_bytes = `EXTRA_TWO;
            default:                              extra_bytes = `EXTRA_ONE;
        endcase
    endfunction : extra_bytes

    function automatic logic is_pointer(input addr_mode_t m);
        case (m)
            mode_ind_s, mode_ind_l, mode_indidx_s, mode_indidx_l,
            mode_rel_i, mode_bit_i, mode_bitrel_i: is_pointer = 1'b1;
            default:                               is_pointer = 1'b0;
        endcase
    endfunction : is_pointer

    // Word pointers belong to the long indirect forms only
    function automatic logic is_word_ptr(input addr_mode_t m);
        is_word_ptr = (m == mode_ind_l) || (m == mode_indidx_l);
    endfunction : is_word_ptr

    function automatic logic is_long(input addr_mode_t m);
        is_long = (m == mode_dir_l) || (m == mode_idx_l) ||
                  (m == mode_ind_l) || (m == mode_indidx_l);
    endfunction : is_long

    function automatic logic is_prebyte(input logic [7:0] pb);
        is_prebyte = (pb == `PREBYTE_INDEX_SWAP) ||
                     (pb == `PREBYTE_INDIRECT_SWAP) ||
                     (pb == `PREBYTE_INDIRECT);
    endfunction : is_prebyte

    function automatic logic swaps_index(input logic [7:0] pb);
        swaps_index = (pb == `PREBYTE_INDEX_SWAP) ||
                      (pb == `PREBYTE_INDIRECT_SWAP);
    endfunction : swaps_index

    // Bytes ahead of the first operand byte: prebyte and opcode
    function automatic logic [2:0] head_len(input logic [7:0] pb);
        head_len = is_prebyte(pb) ? (`PREBYTE_LEN + `OPCODE_LEN) : `OPCODE_LEN;
    endfunction : head_len

    // Mode after the indirect prebytes have acted
    function automatic addr_mode_t promote(input logic [7:0] pb, input addr_mode_t m);
        promote = m;
        if (pb == `PREBYTE_INDIRECT) begin
            case (m)
                mode_dir_s:    promote = mode_ind_s;
                mode_dir_l:    promote = mode_ind_l;
                mode_idx_s:    promote = mode_indidx_s;
                mode_idx_l:    promote = mode_indidx_l;
                mode_rel_d:    promote = mode_rel_i;
                mode_bit_d:    promote = mode_bit_i;
                mode_bitrel_d: promote = mode_bitrel_i;
                default:       promote = m;
            endcase
        end else if (pb == `PREBYTE_INDIRECT_SWAP) begin
            case (m)
                mode_idx_s:    promote = mode_indidx_s;
                mode_idx_l:    promote = mode_indidx_l;
                default:       promote = m;
            endcase
        end
    endfunction : promote

    // A prebyte that has no meaning for the base mode is refused
    function automatic logic bad_prebyte(input logic [7:0] pb, input addr_mode_t m);
        case (pb)
            `PREBYTE_INDEX_SWAP:
                bad_prebyte = !(m inside {mode_inh, mode_imm, mode_dir_s, mode_dir_l,
                                          mode_idx_0, mode_idx_s, mode_idx_l});
            `PREBYTE_INDIRECT:
                bad_prebyte = !(m inside {mode_dir_s, mode_dir_l, mode_idx_s, mode_idx_l,
                                          mode_rel_d, mode_bit_d, mode_bitrel_d});
            `PREBYTE_INDIRECT_SWAP:
                bad_prebyte = !(m inside {mode_idx_s, mode_idx_l});
            default:
                bad_prebyte = 1'b0;
        endcase
    endfunction : bad_prebyte

    function automatic logic [15:0] page_zero(input logic [7:0] b);
        page_zero = {`PAGE_ZERO_HIGH, b};
    endfunction : page_zero

    function automatic logic [15:0] len_word(input logic [2:0] l);
        len_word = {13'h0000, l};
    endfunction : len_word

    dec_state_t  st;
    dec_state_t  next_st;
    addr_mode_t  mode_q;
    logic        use_y_q;
    logic [7:0]  idx_q;
    logic [15:0] pc_q;
    logic [2:0]  len_q;
    logic        err_q;
    mask_op_t    mask_q;
    logic [1:0]  need_q;
    logic        cnt;
    logic [7:0]  opnd_b [0:1];
    logic [7:0]  ptr_b  [0:1];

    // Request side decoding
    wire logic       accept    = req_valid && (st == st_idle);
    wire addr_mode_t req_mode  = promote(req.prebyte, req.mode);
    wire logic       req_use_y = swaps_index(req.prebyte);
    wire logic [1:0] req_extra = extra_bytes(req_mode);
    // Long forms cost operand bytes; RMW refuses them outright
    wire logic       req_err   = (req.rmw && is_long(req_mode)) ||
                                 bad_prebyte(req.prebyte, req.mode);
    wire logic [2:0] req_head  = head_len(req.prebyte);
    wire logic [2:0] req_len   = req_head + {1'b0, req_extra};
    wire logic [15:0] opnd_addr = req.pc + len_word(req_head);
    wire logic       no_fetch  = req_err || (req_extra == `EXTRA_NONE);

    // Fetch progress; an ack outside the fetch states is ignored
    wire logic       opnd_take = (st == st_opnd) && mem_ack;
    wire logic       ptr_take  = (st == st_ptr) && mem_ack;
    wire logic       last_opnd = opnd_take &&
                                 ({1'b0, cnt} + 2'h1 == need_q);
    wire logic       last_ptr  = ptr_take &&
                                 (!is_word_ptr(mode_q) || cnt == `SECOND_BYTE);

    assign req_ready = (st == st_idle);
    assign mem_req   = (st == st_opnd) || (st == st_ptr);

    always_comb begin
        next_st = st;
        case (st)
            st_idle: begin
                if (accept) begin
                    next_st = no_fetch ? st_finish : st_opnd;
                end
            end
            st_opnd: begin
                if (last_opnd) begin
                    next_st = is_pointer(mode_q) ? st_ptr : st_finish;
                end
            end
            st_ptr: begin
                if (last_ptr) begin
                    next_st = st_finish;
                end
            end
            st_finish: begin
                next_st = st_idle;
            end
            default: begin
                next_st = st_idle;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= st_idle;
        end else begin
            st <= next_st;
        end
    end

    // Instruction context captured once per request
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_q  <= mode_inh;
            use_y_q <= 1'b0;
            idx_q   <= 8'h00;
            pc_q    <= 16'h0000;
            len_q   <= `NO_LEN;
            err_q   <= 1'b0;
            mask_q  <= mask_none;
            need_q  <= `EXTRA_NONE;
        end else if (accept) begin
            mode_q  <= req_mode;
            use_y_q <= req_use_y;
            idx_q   <= req_use_y ? index_y : index_x;
            pc_q    <= req.pc;
            len_q   <= req_len;
            err_q   <= req_err;
            mask_q  <= (req_mode == mode_inh) ? req.mask_op : mask_none;
            need_q  <= req_extra;
        end
    end

    // Address sequencing: operand bytes from the stream, then the pointer
    wire logic [15:0] ptr_addr = page_zero((cnt == `FIRST_BYTE) ? mem_rdata : opnd_b[0]);

    always_ff @(posedge mclk) begin
        if (rst) begin
            mem_addr <= 16'h0000;
            cnt      <= `FIRST_BYTE;
        end else if (accept) begin
            mem_addr <= opnd_addr;
            cnt      <= `FIRST_BYTE;
        end else if (last_opnd) begin
            mem_addr <= ptr_addr;
            cnt      <= `FIRST_BYTE;
        end else if (mem_req && mem_ack) begin
            mem_addr <= mem_addr + `ADDR_STEP;
            cnt      <= `SECOND_BYTE;
        end
    end

    // Byte capture; the pointer always sits in the first operand byte
    always_ff @(posedge mclk) begin
        if (rst) begin
            opnd_b[0] <= 8'h00;
            opnd_b[1] <= 8'h00;
            ptr_b[0]  <= 8'h00;
            ptr_b[1]  <= 8'h00;
        end else if (opnd_take) begin
            opnd_b[cnt] <= mem_rdata;
        end else if (ptr_take) begin
            ptr_b[cnt] <= mem_rdata;
        end
    end

    // Effective address forming, high byte first for words
    wire logic [15:0] idx_word  = page_zero(idx_q);
    wire logic [15:0] opnd_s    = page_zero(opnd_b[0]);
    wire logic [15:0] opnd_w    = {opnd_b[0], opnd_b[1]};
    wire logic [15:0] ptr_s     = page_zero(ptr_b[0]);
    wire logic [15:0] ptr_w     = {ptr_b[0], ptr_b[1]};
    // Sums kept 16 bits wide so a 1FE result never wraps into page zero
    wire logic [15:0] sum_opnd_s = opnd_s + idx_word;
    wire logic [15:0] sum_opnd_w = opnd_w + idx_word;
    wire logic [15:0] sum_ptr_s  = ptr_s + idx_word;
    wire logic [15:0] sum_ptr_w  = ptr_w + idx_word;

    logic [15:0] ea_sel;
    logic        ea_ok;
    always_comb begin
        ea_ok  = 1'b1;
        ea_sel = 16'h0000;
        case (mode_q)
            mode_dir_s:    ea_sel = opnd_s;
            mode_dir_l:    ea_sel = opnd_w;
            mode_idx_0:    ea_sel = idx_word;
            mode_idx_s:    ea_sel = sum_opnd_s;
            mode_idx_l:    ea_sel = sum_opnd_w;
            mode_ind_s:    ea_sel = ptr_s;
            mode_ind_l:    ea_sel = ptr_w;
            mode_indidx_s: ea_sel = sum_ptr_s;
            mode_indidx_l: ea_sel = sum_ptr_w;
            mode_bit_d:    ea_sel = opnd_s;
            mode_bit_i:    ea_sel = ptr_s;
            mode_bitrel_d: ea_sel = opnd_s;
            mode_bitrel_i: ea_sel = ptr_s;
            default:       ea_ok  = 1'b0;
        endcase
    end

    // Relative offset source; indirect relative takes it from memory
    wire logic       rel_ok  = mode_q inside {mode_rel_d, mode_rel_i,
                                              mode_bitrel_d, mode_bitrel_i};
    wire logic [7:0] rel_off = (mode_q == mode_rel_d) ? opnd_b[0] :
                               (mode_q == mode_rel_i) ? ptr_b[0]  : opnd_b[1];
    wire logic [15:0] pc_next = pc_q + len_word(len_q);
    wire logic [15:0] rel_word = {{8{rel_off[7]}}, rel_off};
    wire logic [15:0] target  = pc_next + rel_word;

    // Result qualifiers; an error clears every valid except valid itself
    wire logic       imm_ok    = (mode_q == mode_imm) && !err_q;
    wire logic       mask_ok   = (mask_q != mask_none) && !err_q;
    wire logic [1:0] level_sel = (mask_q == mask_set) ? `MASK_LEVEL_SET : `MASK_LEVEL_RESET;

    dec_res_t built;
    always_comb begin
        built               = '0;
        built.valid         = 1'b1;
        built.error         = err_q;
        built.mode          = mode_q;
        built.use_y         = use_y_q;
        built.length        = len_q;
        built.ea_valid      = ea_ok && !err_q;
        built.ea            = ea_sel;
        built.imm_valid     = imm_ok;
        built.imm           = opnd_b[0];
        built.branch_valid  = rel_ok && !err_q;
        built.branch_target = target;
        built.mask_write    = mask_ok;
        built.mask_level    = level_sel;
    end

    // Result holds its fields; valid lasts one cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            res <= '0;
        end else if (st == st_finish) begin
            res <= built;
        end else begin
            res.valid <= 1'b0;
        end
    end

endmodule : cpu_operand_address_generator

//--- tb/opgen_props.sv
// Assertions on the ports of the operand address generator.
// Assumes one mclk domain and a synchronous rst.
module opgen_props (
    input wire logic                 mclk,
    input wire logic                 rst,
    input wire logic                 req_valid,
    input wire logic                 req_ready,
    input wire opgen_pkg::dec_req_t  req,
    input wire logic [7:0]           index_x,
    input wire logic [7:0]           index_y,
    input wire logic                 mem_req,
    input wire logic [15:0]          mem_addr,
    input wire logic [7:0]           mem_rdata,
    input wire logic                 mem_ack,
    input wire opgen_pkg::dec_res_t  res
);
    timeunit 1ns;
    timeprecision 1ns;
    import opgen_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Request as taken, since res only shows the promoted mode
    dec_req_t acc;
    always_ff @(posedge mclk) begin
        if (rst) begin
            acc <= '0;
        end else if (req_valid && req_ready) begin
            acc <= req;
        end
    end
    function automatic logic [2:0] exp_len(input logic [7:0] pb, input addr_mode_t m);
        logic [2:0] n;
        n = (m inside {mode_inh, mode_idx_0}) ? 3'h0 :
            (m inside {mode_dir_l, mode_idx_l, mode_bitrel_d, mode_bitrel_i}) ? 3'h2 : 3'h1;
        return n + 3'h1 + ((pb inside {8'h90, 8'h91, 8'h92}) ? 3'h1 : 3'h0);
    endfunction : exp_len
    property p_rmw_long;
        res.valid && acc.rmw && acc.prebyte == 8'h00 && acc.mode inside {mode_dir_l, mode_idx_l}
            |-> res.error && !res.ea_valid;
    endproperty
    a_rmw_long: assert property (p_rmw_long) else $error("long form taken on rmw");
    property p_inh;
        req_valid && req_ready && req.mode == mode_inh && req.prebyte == 8'h00
            |=> !mem_req ##1 res.valid && res.length == 3'h1 && !res.ea_valid;
    endproperty
    a_inh: assert property (p_inh) else $error("inherent not one byte");
    property p_page0;
        res.valid && !res.error && res.mode inside {mode_dir_s, mode_ind_s, mode_bit_d}
            |-> res.ea_valid && res.ea[15:8] == 8'h00;
    endproperty
    a_page0: assert property (p_page0) else $error("short form left page zero");
    property p_idx0;
        req_valid && req_ready && req.mode == mode_idx_0 && req.prebyte == 8'h00
            |=> !mem_req ##1 res.valid && res.ea == {8'h00, $past(index_x, 2)};
    endproperty
    a_idx0: assert property (p_idx0) else $error("no-offset index wrong");
    property p_sum;
        res.valid && !res.error && res.mode inside {mode_idx_s, mode_indidx_s} |-> res.ea <= 16'h01fe;
    endproperty
    a_sum: assert property (p_sum) else $error("short indexed beyond 1fe");
    property p_mask;
        res.valid && !res.error && acc.mode == mode_inh && acc.mask_op != mask_none
            |-> res.mask_write && res.mask_level == (acc.mask_op == mask_set ? 2'h3 : 2'h0);
    endproperty
    a_mask: assert property (p_mask) else $error("mask level wrong");
    property p_len;
        res.valid && !res.error |-> res.length == exp_len(acc.prebyte, res.mode);
    endproperty
    a_len: assert property (p_len) else $error("length wrong");
    property p_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("read dropped before ack");
endmodule : opgen_props

bind cpu_operand_address_generator opgen_props chk (
    .mclk(mclk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .index_x(index_x), .index_y(index_y), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .res(res));

//--- tb/opgen_mem_model.sv
// Byte-wide memory partner: answers each read after a chosen wait.
// Assumes mem_req and mem_addr hold until acknowledged.
module opgen_mem_model (
    input  wire logic        mclk,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic [7:0]       mem_rdata,
    output logic             mem_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    int         waited;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
        waited = 0;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'ha5;
        end
    end
    always @(posedge mclk) begin
        #2;
        if (mem_req && !mem_ack && waited >= (slow ? 3 : 0)) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr];
            waited <= 0;
        end else begin
            // Idle bus carries junk: the last byte inverted, then the byte itself, in turn
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            waited <= mem_req ? waited + 1 : 0;
        end
    end
endmodule : opgen_mem_model

//--- tb/testbench.sv
// Self-checking bench for the operand address generator.
// Assumes the memory partner model and the bound checker.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import opgen_pkg::*;
    logic       mclk, rst, req_valid, req_ready, slow, mem_req, mem_ack;
    dec_req_t   req;
    dec_res_t   res;
    logic [7:0] index_x, index_y, mem_rdata;
    logic [15:0] mem_addr;
    int         n_errors, samples_checked, cycles;
    cpu_operand_address_generator uut (.mclk(mclk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .index_x(index_x), .index_y(index_y),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .res(res));
    opgen_mem_model mm (.mclk(mclk), .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    function automatic logic [7:0] m(input logic [15:0] a);
        return mm.mem[a];
    endfunction : m
    function automatic logic [15:0] sx(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction : sx
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Holds the request until an edge sees ready, then waits for the result
    task automatic run(input logic [7:0] pb, input addr_mode_t md, input logic [15:0] pc,
                       input logic [2:0] rm = 3'h0);
        int n;
        req = {pb, md, rm, pc};
        req_valid = 1'b1;
        while (req_ready !== 1'b1) begin
            @(posedge mclk);
            #2;
        end
        @(posedge mclk);
        #2;
        req_valid = 1'b0;
        n = 0;
        while (res.valid !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #2;
            n++;
        end
        check(16'(n < 100), 16'h0001);
    endtask : run
    task automatic t_inh();
        run(8'h00, mode_inh, 16'h0100, {1'b0, mask_set});
        check(res.length, 3'h1);
        check({res.mask_write, res.mask_level}, 3'h7);
        run(8'h00, mode_inh, 16'h0101, {1'b0, mask_reset});
        check({res.mask_write, res.mask_level}, 3'h4);
        run(8'h90, mode_inh, 16'h0102);
        check({res.use_y, res.length, res.mask_write}, 5'h14);
    endtask : t_inh
    task automatic t_imm_dir();
        run(8'h00, mode_imm, 16'h0210);
        check({res.imm_valid, res.imm, res.length}, {1'b1, m(16'h0211), 3'h2});
        run(8'h90, mode_imm, 16'h0220);
        check({res.use_y, res.imm, res.length}, {1'b1, m(16'h0222), 3'h3});
        slow = 1'b1;
        run(8'h00, mode_dir_s, 16'h0330);
        check(res.ea, {8'h00, m(16'h0331)});
        run(8'h00, mode_dir_l, 16'h0340);
        check(res.ea, {m(16'h0341), m(16'h0342)});
        slow = 1'b0;
    endtask : t_imm_dir
    task automatic t_idx();
        index_x = 8'hff;
        index_y = 8'h3c;
        run(8'h00, mode_idx_0, 16'h0400);
        check(res.ea, 16'h00ff);
        mm.mem[16'h0411] = 8'hff;
        run(8'h00, mode_idx_s, 16'h0410);
        check(res.ea, 16'h01fe);
        run(8'h90, mode_idx_l, 16'h0420);
        check(res.ea, {m(16'h0422), m(16'h0423)} + 16'h003c);
    endtask : t_idx
    task automatic t_ind();
        index_x = 8'h80;
        index_y = 8'hf0;
        run(8'h92, mode_dir_s, 16'h0500);
        check(res.ea, {8'h00, m({8'h00, m(16'h0502)})});
        check({res.mode, res.length}, {mode_ind_s, 3'h3});
        mm.mem[16'h0512] = 8'hff;
        run(8'h92, mode_dir_l, 16'h0510);
        check(res.ea, {m(16'h00ff), m(16'h0100)});
        run(8'h92, mode_idx_s, 16'h0600);
        check(res.ea, {8'h00, m({8'h00, m(16'h0602)})} + 16'h0080);
        mm.mem[16'h0612] = 8'h50;
        run(8'h91, mode_idx_l, 16'h0610);
        check(res.ea, {m(16'h0050), m(16'h0051)} + 16'h00f0);
        check({res.mode, res.use_y}, {mode_indidx_l, 1'b1});
    endtask : t_ind
    task automatic t_rel();
        mm.mem[16'h0701] = 8'h80;
        run(8'h00, mode_rel_d, 16'h0700);
        check(res.branch_target, 16'h0682);
        mm.mem[16'h0712] = 8'h44;
        mm.mem[16'h0044] = 8'h7f;
        run(8'h92, mode_rel_d, 16'h0710);
        check(res.branch_valid, 1'b1);
        check(res.branch_target, 16'h0792);
        run(8'h00, mode_bitrel_d, 16'h0720);
        check(res.branch_target, 16'h0723 + sx(m(16'h0722)));
        run(8'h92, mode_bitrel_d, 16'h0730);
        check(res.ea, {8'h00, m({8'h00, m(16'h0732)})});
        check(res.branch_target, 16'h0734 + sx(m(16'h0733)));
        run(8'h00, mode_bit_d, 16'h0740);
        check(res.ea, {8'h00, m(16'h0741)});
        run(8'h92, mode_bit_d, 16'h0750);
        check(res.mode, mode_bit_i);
        check(res.ea, {8'h00, m({8'h00, m(16'h0752)})});
    endtask : t_rel
    task automatic t_err();
        run(8'h92, mode_dir_l, 16'h0800, 3'h4);
        check({res.error, res.ea_valid}, 2'h2);
        run(8'h00, mode_idx_l, 16'h0810, 3'h4);
        check({res.error, res.ea_valid}, 2'h2);
        run(8'h00, mode_dir_s, 16'h0820, 3'h4);
        check({res.error, res.ea_valid}, 2'h1);
        run(8'h91, mode_dir_s, 16'h0830);
        check(res.error, 1'b1);
    endtask : t_err
    // Reset in mid-fetch drops the read and leaves the block idle
    task automatic t_rst();
        slow = 1'b1;
        req = {8'h00, mode_dir_l, 3'h0, 16'h0900};
        req_valid = 1'b1;
        @(posedge mclk);
        #2;
        req_valid = 1'b0;
        @(posedge mclk);
        #2;
        check(mem_req, 1'b1);
        rst = 1'b1;
        @(posedge mclk);
        #2;
        rst = 1'b0;
        check({req_ready, mem_req, res.valid, res.error, res.length}, 7'h40);
        check(mem_addr, 16'h0000);
        check(res.ea, 16'h0000);
        run(8'h00, mode_dir_l, 16'h0900);
        check(res.ea, {m(16'h0901), m(16'h0902)});
        slow = 1'b0;
    endtask : t_rst
    // Cuts a hang short; the run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        index_x = 8'h00;
        index_y = 8'h00;
        slow = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (3) @(posedge mclk);
        #2;
        rst = 1'b0;
        t_inh();
        t_imm_dir();
        t_idx();
        t_ind();
        t_rel();
        t_err();
        t_rst();
        print_verdict();
    end
endmodule : testbench
